/* logic/pio_params.svh */
// offsets, field positions and reset values of the port i/o engine
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
// ===========================================
// register byte offsets
`define PIO_OFF_CTRL  8'h00
`define PIO_OFF_ACC   8'h04
`define PIO_OFF_PIDX  8'h08
`define PIO_OFF_CNT   8'h0C
`define PIO_OFF_DIDX  8'h10
`define PIO_OFF_SIDX  8'h14
`define PIO_OFF_ESEG  8'h18
`define PIO_OFF_DSEG  8'h1C
`define PIO_OFF_STAT  8'h20
`define PIO_OFF_MASK  8'h24
// ===========================================
// control word fields
`define PIO_CTL_OP    1:0
`define PIO_CTL_WORD  2
`define PIO_CTL_IDX   3
`define PIO_CTL_REP   4
`define PIO_CTL_PROT  5
`define PIO_CTL_CPL   7:6
`define PIO_CTL_IO_PRIV_THRESHOLD  9:8
`define PIO_CTL_DIR   10
`define PIO_CTL_IMM   23:16
`define PIO_CTL_GO    31
`define PIO_CTL_MASK  32'h00FF_07FF
// ===========================================
// status bits and reset values
`define PIO_ST_DONE   0
`define PIO_ST_FAULT  1
`define PIO_ST_BUSY   2
`define PIO_RST_CTRL  32'h0000_0000
`define PIO_RST_WORD  16'h0000
`define PIO_RST_MASK  2'h0
`endif

/* logic/pio_pkg.sv */
// types shared by the port i/o engine
package pio_pkg;
  typedef enum logic [1:0] {
    op_port_in, op_port_out, port_block_read_op, port_block_write_op
  } op_e;
  typedef logic [15:0] word_t;
  typedef logic [19:0] phys_t;
endpackage

/* logic/reg_if.sv */
// register access carrier between bus front end and engine
`timescale 1ns/1ps
interface reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport front (output wr, output addr, output wdata, input rdata);
  modport regs  (input wr, input addr, input wdata, output rdata);
endinterface

/* logic/ahb_front.sv */
// ahb-lite slave front end with one wait state per transfer
`timescale 1ns/1ps
module ahb_front (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  reg_if.front             rb
);
  logic       dp_q, dp_d, wr_q, wr_d, rdy_d;
  logic [7:0] a_q, a_d;
  logic [31:0] rd_d;
  // ===========================================
  // address phase capture; wait state lets read data come from a flop
  always_comb begin
    dp_d  = 1'b0;
    rdy_d = 1'b1;
    a_d   = a_q;
    wr_d  = wr_q;
    rd_d  = hrdata;
    if (hsel && htrans[1] && hready) begin
      dp_d  = 1'b1;
      rdy_d = 1'b0;
      // addresses beyond the map decode to a hole that reads zero
      a_d   = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
      wr_d  = hwrite;
    end
    if (dp_q) begin
      rd_d = wr_q ? 32'h0000_0000 : rb.rdata;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q      <= 1'b0;
      wr_q      <= 1'b0;
      a_q       <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      dp_q      <= dp_d;
      wr_q      <= wr_d;
      a_q       <= a_d;
      hreadyout <= rdy_d;
      hrdata    <= rd_d;
      hresp     <= 1'b0; // always okay
    end
  end
  assign rb.wr    = dp_q & wr_q;
  assign rb.addr  = a_q;
  assign rb.wdata = hwdata;
endmodule

/* logic/io_gate.sv */
// privilege gate and port number resolution
`timescale 1ns/1ps
module io_gate (
  input  wire logic          prot_mode,
  input  wire logic [1:0]    current_priv_level,
  input  wire logic [1:0]    io_priv_threshold,
  input  wire pio_pkg::op_e  op,
  input  wire logic          use_index,
  input  wire logic          word,
  input  wire logic [7:0]    imm_port,
  input  wire pio_pkg::word_t port_index_reg,
  output logic               allowed,
  output pio_pkg::word_t     port
);
  import pio_pkg::*;
  word_t raw;
  // ===========================================
  // real mode skips the check; protected mode needs level <= threshold
  assign allowed = !prot_mode || (current_priv_level <= io_priv_threshold);
  // block ops always use the index register; others may use the immediate
  always_comb begin
    if (op == port_block_read_op || op == port_block_write_op || use_index) begin
      raw = port_index_reg;
    end else begin
      raw = {8'h00, imm_port};
    end
  end
  // word ports are even: the low address bit is forced clear
  assign port = word ? {raw[15:1], 1'b0} : raw;
endmodule

/* logic/port_io_exec.sv */
// port and block i/o execution engine with ahb-lite registers
// Operation
// - protected mode needs privilege level <= threshold
// - insufficient privilege raises protection exception
// - byte reads fill low byte, word full
// - immediate port: 256 bytes, even words
// - index register port spans whole 16-bit range
// - writes send low byte or word
// - byte/word forms; pointer steps one or two
// - direction flag zero increments, one decrements
// - block read stores at extra segment:dest
// - block ops always use index register port
// - block write fetches from data segment:source
// - repeat decrements counter, stops at zero
// - dest index adjusted after counter decrement
// - source index adjusted after counter decrement
// - real mode skips privilege check
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "pio_params.svh"
module port_io_exec (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic           hready,
  input  wire logic [31:0]    hwdata,
  output logic                hreadyout,
  output logic [31:0]         hrdata,
  output logic                hresp,
  output pio_pkg::word_t      io_port,
  output pio_pkg::word_t      io_wdata,
  output logic                io_rd,
  output logic                io_wr,
  output logic                io_word,
  input  wire pio_pkg::word_t io_rdata,
  input  wire logic           io_ack,
  output pio_pkg::phys_t      mem_addr,
  output pio_pkg::word_t      mem_wdata,
  output logic                mem_rd,
  output logic                mem_wr,
  output logic                mem_word,
  input  wire pio_pkg::word_t mem_rdata,
  input  wire logic           mem_ack,
  output logic                prot_fault,
  output logic                irq
);
  import pio_pkg::*;
  typedef enum logic [2:0] {st_idle, st_io, st_mem, st_step} state_e;
  reg_if rb ();
  // ===========================================
  // bus front end
  ahb_front u_front (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .rb        (rb.front)
  );
  state_e      st_q, st_d;
  logic [31:0] ctrl_q, ctrl_d;
  word_t       acc_q, acc_d, pidx_q, pidx_d, cnt_q, cnt_d;
  word_t       didx_q, didx_d, sidx_q, sidx_d, eseg_q, eseg_d, dseg_q, dseg_d;
  logic [1:0]  stat_q, stat_d, mask_q, mask_d;
  logic        irq_d, fault_d, start_q, start_d;
  word_t       io_port_d, io_wdata_d, mem_wdata_d;
  phys_t       mem_addr_d;
  logic        io_rd_d, io_wr_d, io_word_d, mem_rd_d, mem_wr_d, mem_word_d;
  op_e         op;
  logic        word, block_loop_prefix, dir, allowed, go, set_done, set_fault;
  word_t       port, step, cnt_n;
  assign op   = op_e'(ctrl_q[`PIO_CTL_OP]);
  assign word = ctrl_q[`PIO_CTL_WORD];
  assign block_loop_prefix  = ctrl_q[`PIO_CTL_REP];
  assign dir  = ctrl_q[`PIO_CTL_DIR];
  // ===========================================
  // privilege and port resolution
  io_gate u_gate (
    .prot_mode          (ctrl_q[`PIO_CTL_PROT]),
    .current_priv_level (ctrl_q[`PIO_CTL_CPL]),
    .io_priv_threshold  (ctrl_q[`PIO_CTL_IO_PRIV_THRESHOLD]),
    .op                 (op),
    .use_index          (ctrl_q[`PIO_CTL_IDX]),
    .word               (word),
    .imm_port           (ctrl_q[`PIO_CTL_IMM]),
    .port_index_reg     (pidx_q),
    .allowed            (allowed),
    .port               (port)
  );
  // pointer step by element size
  assign step  = word ? 16'h0002 : 16'h0001;
  assign cnt_n = block_loop_prefix ? cnt_q - 16'h0001 : cnt_q;
  // segment base plus offset
  function automatic phys_t phys(input word_t seg, input word_t off);
    phys = {seg, 4'h0} + {4'h0, off};
  endfunction
  // a start is taken only from idle; writes while busy are dropped except to status and mask
  assign go = rb.wr && (rb.addr == `PIO_OFF_CTRL) && rb.wdata[`PIO_CTL_GO] && (st_q == st_idle);
  // ===========================================
  // register read mux
  always_comb begin
    rb.rdata = 32'h0000_0000;
    unique case (rb.addr)
      `PIO_OFF_CTRL: rb.rdata = ctrl_q;
      `PIO_OFF_ACC:  rb.rdata = {16'h0000, acc_q};
      `PIO_OFF_PIDX: rb.rdata = {16'h0000, pidx_q};
      `PIO_OFF_CNT:  rb.rdata = {16'h0000, cnt_q};
      `PIO_OFF_DIDX: rb.rdata = {16'h0000, didx_q};
      `PIO_OFF_SIDX: rb.rdata = {16'h0000, sidx_q};
      `PIO_OFF_ESEG: rb.rdata = {16'h0000, eseg_q};
      `PIO_OFF_DSEG: rb.rdata = {16'h0000, dseg_q};
      `PIO_OFF_STAT: rb.rdata = {29'h0000_0000, st_q != st_idle, stat_q};
      `PIO_OFF_MASK: rb.rdata = {30'h0000_0000, mask_q};
      default:       rb.rdata = 32'h0000_0000;
    endcase
  end
  // ===========================================
  // engine next state
  always_comb begin
    st_d        = st_q;
    ctrl_d      = ctrl_q;
    acc_d       = acc_q;
    pidx_d      = pidx_q;
    cnt_d       = cnt_q;
    didx_d      = didx_q;
    sidx_d      = sidx_q;
    eseg_d      = eseg_q;
    dseg_d      = dseg_q;
    start_d     = go; // decode waits a cycle so the new control word stands
    io_port_d   = io_port;
    io_wdata_d  = io_wdata;
    io_rd_d     = io_rd;
    io_wr_d     = io_wr;
    io_word_d   = io_word;
    mem_addr_d  = mem_addr;
    mem_wdata_d = mem_wdata;
    mem_rd_d    = mem_rd;
    mem_wr_d    = mem_wr;
    mem_word_d  = mem_word;
    set_done    = 1'b0;
    set_fault   = 1'b0;
    // software writes other than status and mask land only while idle, so the engine owns its state
    if (rb.wr && st_q == st_idle) begin
      unique case (rb.addr)
        `PIO_OFF_CTRL: ctrl_d = rb.wdata & `PIO_CTL_MASK;
        `PIO_OFF_ACC:  acc_d  = rb.wdata[15:0];
        `PIO_OFF_PIDX: pidx_d = rb.wdata[15:0];
        `PIO_OFF_CNT:  cnt_d  = rb.wdata[15:0];
        `PIO_OFF_DIDX: didx_d = rb.wdata[15:0];
        `PIO_OFF_SIDX: sidx_d = rb.wdata[15:0];
        `PIO_OFF_ESEG: eseg_d = rb.wdata[15:0];
        `PIO_OFF_DSEG: dseg_d = rb.wdata[15:0];
        default: ;
      endcase
    end
    unique case (st_q)
      st_idle: begin
        if (start_q) begin
          if (!allowed) begin
            set_fault = 1'b1;
          end else if ((op == port_block_read_op || op == port_block_write_op)
                       && block_loop_prefix && cnt_q == 16'h0000) begin
            set_done = 1'b1;
          end else begin
            io_port_d = port;
            io_word_d = word;
            unique case (op)
              op_port_in, port_block_read_op: begin
                io_rd_d = 1'b1;
                st_d    = st_io;
              end
              op_port_out: begin
                io_wdata_d = word ? acc_q : {8'h00, acc_q[7:0]};
                io_wr_d    = 1'b1;
                st_d       = st_io;
              end
              port_block_write_op: begin
                mem_addr_d = phys(dseg_q, sidx_q);
                mem_word_d = word;
                mem_rd_d   = 1'b1;
                st_d       = st_mem;
              end
            endcase
          end
        end
      end
      st_io: begin
        if (io_ack) begin
          io_rd_d = 1'b0;
          io_wr_d = 1'b0;
          unique case (op)
            op_port_in: begin
              // byte read keeps the accumulator high byte
              acc_d    = word ? io_rdata : {acc_q[15:8], io_rdata[7:0]};
              set_done = 1'b1;
              st_d     = st_idle;
            end
            op_port_out: begin
              set_done = 1'b1;
              st_d     = st_idle;
            end
            port_block_read_op: begin
              // destination segment is fixed; no override reaches it
              mem_addr_d  = phys(eseg_q, didx_q);
              mem_wdata_d = word ? io_rdata : {8'h00, io_rdata[7:0]};
              mem_word_d  = word;
              mem_wr_d    = 1'b1;
              st_d        = st_mem;
            end
            port_block_write_op: st_d = st_step;
          endcase
        end
      end
      st_mem: begin
        if (mem_ack) begin
          mem_rd_d = 1'b0;
          mem_wr_d = 1'b0;
          if (op == port_block_write_op) begin
            io_wdata_d = word ? mem_rdata : {8'h00, mem_rdata[7:0]};
            io_wr_d    = 1'b1;
            st_d       = st_io;
          end else begin
            st_d = st_step;
          end
        end
      end
      st_step: begin
        cnt_d = cnt_n;
        // pointer moves in the same cycle as, and after, the decrement
        if (op == port_block_read_op) begin
          didx_d = dir ? didx_q - step : didx_q + step;
        end else begin
          sidx_d = dir ? sidx_q - step : sidx_q + step;
        end
        if (block_loop_prefix && cnt_n != 16'h0000) begin
          // next element: port number is re-read from the index register
          io_port_d = port;
          if (op == port_block_read_op) begin
            io_rd_d = 1'b1;
            st_d    = st_io;
          end else begin
            mem_addr_d = phys(dseg_q, dir ? sidx_q - step : sidx_q + step);
            mem_rd_d   = 1'b1;
            st_d       = st_mem;
          end
        end else begin
          set_done = 1'b1;
          st_d     = st_idle;
        end
      end
      default: st_d = st_idle;
    endcase
  end
  // ===========================================
  // sticky status, mask and interrupt; a set wins over a same-cycle clear
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (rb.wr && rb.addr == `PIO_OFF_STAT) begin
      stat_d = stat_q & ~rb.wdata[1:0];
    end
    if (rb.wr && rb.addr == `PIO_OFF_MASK) begin
      mask_d = rb.wdata[1:0];
    end
    if (set_done) begin
      stat_d[`PIO_ST_DONE] = 1'b1;
    end
    if (set_fault) begin
      stat_d[`PIO_ST_FAULT] = 1'b1;
    end
    irq_d   = |(stat_d & mask_d);
    fault_d = set_fault; // one-cycle exception pulse
  end
  // ===========================================
  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= st_idle;
      ctrl_q     <= `PIO_RST_CTRL;
      acc_q      <= `PIO_RST_WORD;
      pidx_q     <= `PIO_RST_WORD;
      cnt_q      <= `PIO_RST_WORD;
      didx_q     <= `PIO_RST_WORD;
      sidx_q     <= `PIO_RST_WORD;
      eseg_q     <= `PIO_RST_WORD;
      dseg_q     <= `PIO_RST_WORD;
      start_q    <= 1'b0;
      stat_q     <= 2'h0;
      mask_q     <= `PIO_RST_MASK;
      irq        <= 1'b0;
      prot_fault <= 1'b0;
      io_port    <= `PIO_RST_WORD;
      io_wdata   <= `PIO_RST_WORD;
      io_rd      <= 1'b0;
      io_wr      <= 1'b0;
      io_word    <= 1'b0;
      mem_addr   <= 20'h0_0000;
      mem_wdata  <= `PIO_RST_WORD;
      mem_rd     <= 1'b0;
      mem_wr     <= 1'b0;
      mem_word   <= 1'b0;
    end else begin
      st_q       <= st_d;
      ctrl_q     <= ctrl_d;
      acc_q      <= acc_d;
      pidx_q     <= pidx_d;
      cnt_q      <= cnt_d;
      didx_q     <= didx_d;
      sidx_q     <= sidx_d;
      eseg_q     <= eseg_d;
      dseg_q     <= dseg_d;
      start_q    <= start_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      irq        <= irq_d;
      prot_fault <= fault_d;
      io_port    <= io_port_d;
      io_wdata   <= io_wdata_d;
      io_rd      <= io_rd_d;
      io_wr      <= io_wr_d;
      io_word    <= io_word_d;
      mem_addr   <= mem_addr_d;
      mem_wdata  <= mem_wdata_d;
      mem_rd     <= mem_rd_d;
      mem_wr     <= mem_wr_d;
      mem_word   <= mem_word_d;
    end
  end
endmodule

/* verif/pio_checker.sv */
// concurrent checks on the ports of the port i/o engine
`timescale 1ns/1ps
module pio_checker (
  input wire logic           hclk,
  input wire logic           hresetn,
  input wire logic           hsel,
  input wire logic [1:0]     htrans,
  input wire logic           hready,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire pio_pkg::word_t io_port,
  input wire pio_pkg::word_t io_wdata,
  input wire logic           io_rd,
  input wire logic           io_wr,
  input wire logic           io_word,
  input wire logic           io_ack,
  input wire pio_pkg::phys_t mem_addr,
  input wire pio_pkg::word_t mem_wdata,
  input wire logic           mem_rd,
  input wire logic           mem_wr,
  input wire logic           mem_word,
  input wire logic           mem_ack,
  input wire logic           prot_fault
);
  import pio_pkg::*;
  // ===========================================
  // one clock domain, so clocking and reset are shared
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_wait_state: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take exactly one wait state");
  chk_io_hold: assert property ((io_rd || io_wr) && !io_ack |=>
    (io_rd || io_wr) && $stable(io_port) && $stable(io_wdata) && $stable(io_word))
    else $error("port request changed before acknowledge");
  chk_io_drop: assert property ((io_rd || io_wr) && io_ack |=> !io_rd && !io_wr)
    else $error("port request not released after acknowledge");
  chk_mem_hold: assert property ((mem_rd || mem_wr) && !mem_ack |=>
    (mem_rd || mem_wr) && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before acknowledge");
  chk_one_side: assert property (!((io_rd || io_wr) && (mem_rd || mem_wr)))
    else $error("port and memory requests overlap");
  chk_word_even: assert property ((io_rd || io_wr) && io_word |-> !io_port[0])
    else $error("word access on an odd port");
  chk_byte_data: assert property (io_wr && !io_word |-> io_wdata[15:8] == 8'h00)
    else $error("byte write carries upper bits");
  chk_fault_pulse: assert property (prot_fault |=> !prot_fault && !io_rd && !io_wr)
    else $error("refused start still pulsed or transferred");
  chk_mem_size: assert property ((mem_rd || mem_wr) |-> mem_word == io_word)
    else $error("memory element size differs from port size");
endmodule
bind port_io_exec pio_checker chk_u (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout,
  .hresp, .io_port, .io_wdata, .io_rd, .io_wr, .io_word, .io_ack, .mem_addr, .mem_wdata,
  .mem_rd, .mem_wr, .mem_word, .mem_ack, .prot_fault);

/* verif/pio_periph.sv */
// model of the peripheral ports and memory beyond the port i/o engine
`timescale 1ns/1ps
module pio_periph (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire pio_pkg::word_t io_port,
  input  wire pio_pkg::word_t io_wdata,
  input  wire logic           io_rd,
  input  wire logic           io_wr,
  output pio_pkg::word_t      io_rdata,
  output logic                io_ack,
  input  wire pio_pkg::phys_t mem_addr,
  input  wire pio_pkg::word_t mem_wdata,
  input  wire logic           mem_rd,
  input  wire logic           mem_wr,
  output pio_pkg::word_t      mem_rdata,
  output logic                mem_ack
);
  import pio_pkg::*;
  word_t      m [256];
  word_t      last_port;
  word_t      last_wdata;
  int         n_io;
  logic       slow_q;
  logic [1:0] wait_q;
  logic       busy;
  assign busy = (io_rd || io_wr || mem_rd || mem_wr) && !io_ack && !mem_ack;
  // answers alternate between prompt and three cycles late; data toggles outside acks
  // so a design sampling at the wrong edge never sees a stale match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_ack <= 1'b0;
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      slow_q <= 1'b0;
      n_io <= 0;
      last_port <= 16'h0;
      last_wdata <= 16'h0;
      io_rdata <= 16'h0;
      mem_rdata <= 16'h0;
      for (int i = 0; i < 256; i++) m[i] <= {8'hA0, i[7:0]};
    end else begin
      io_ack <= 1'b0;
      mem_ack <= 1'b0;
      io_rdata <= ~io_rdata;
      mem_rdata <= ~mem_rdata;
      if (busy && wait_q != (slow_q ? 2'h3 : 2'h0)) begin
        wait_q <= wait_q + 2'h1;
      end else if (busy) begin
        wait_q <= 2'h0;
        slow_q <= !slow_q;
        if (io_rd || io_wr) begin
          io_ack <= 1'b1;
          n_io <= n_io + 1;
          last_port <= io_port;
          last_wdata <= io_wdata;
          io_rdata <= ~io_port; // port data derived from its number
        end else begin
          mem_ack <= 1'b1;
          mem_rdata <= m[mem_addr[7:0]];
          if (mem_wr) m[mem_addr[7:0]] <= mem_wdata;
        end
      end
    end
  end
endmodule

/* verif/testbench.sv */
// self-checking bench for the port i/o engine
`timescale 1ns/1ps
`include "pio_params.svh"
module testbench;
  import pio_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, prot_fault, irq;
  logic        io_rd, io_wr, io_word, io_ack, mem_rd, mem_wr, mem_word, mem_ack;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  word_t       io_port, io_wdata, io_rdata, mem_wdata, mem_rdata;
  phys_t       mem_addr;
  int          error_cnt, comparisons, n0, n_flt, f0;
  logic [5:0]  pv [5] = '{6'h17, 6'h15, 6'h19, 6'h06, 6'h03};
  logic [4:0]  pf = 5'h11;
  port_io_exec dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hreadyout, .hrdata, .hresp, .io_port, .io_wdata, .io_rd,
    .io_wr, .io_word, .io_rdata, .io_ack, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_word,
    .mem_rdata, .mem_ack, .prot_fault, .irq);
  pio_periph periph_u (.hclk, .hresetn, .io_port, .io_wdata, .io_rd, .io_wr, .io_rdata,
    .io_ack, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata, .mem_ack);
  // the fault pulse lasts one cycle, so count it here where polling cannot miss it
  always @(posedge hclk) begin
    if (prot_fault === 1'b1) n_flt <= n_flt + 1;
  end
  // ===========================================
  // clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #300000;
    error_cnt++;
    results();
  end
  // ===========================================
  // bus tasks: master waits for hready, no fixed latency assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic setup(input logic [15:0] p, e, d, di, si, c);
    xfer(1'b1, `PIO_OFF_PIDX, {16'h0, p});
    xfer(1'b1, `PIO_OFF_ESEG, {16'h0, e});
    xfer(1'b1, `PIO_OFF_DSEG, {16'h0, d});
    xfer(1'b1, `PIO_OFF_DIDX, {16'h0, di});
    xfer(1'b1, `PIO_OFF_SIDX, {16'h0, si});
    xfer(1'b1, `PIO_OFF_CNT, {16'h0, c});
  endtask
  // control word: wir = {repeat, index, word}, pcid = {dir, threshold, level, protected}
  function automatic logic [31:0] ctl(input logic [1:0] op, input logic [2:0] wir,
                                      input logic [5:0] pcid, input logic [7:0] imm);
    return {1'b1, 7'h0, imm, 5'h0, pcid, wir, op};
  endfunction
  // clears status, starts, then polls until done or fault
  task automatic run(input logic [31:0] c);
    xfer(1'b1, `PIO_OFF_STAT, 32'h3);
    n0 = periph_u.n_io;
    f0 = n_flt;
    xfer(1'b1, `PIO_OFF_CTRL, c);
    for (int i = 0; i < 60; i++) begin
      xfer(1'b0, `PIO_OFF_STAT, 32'h0);
      if (rv[1:0] != 2'h0) break;
    end
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ===========================================
  // scenarios
  initial begin
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hresetn = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`PIO_OFF_CTRL, `PIO_RST_CTRL);
    rdchk(`PIO_OFF_STAT, 32'h0);
    xfer(1'b1, 8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0);
    xfer(1'b1, `PIO_OFF_MASK, 32'h3);
    xfer(1'b1, `PIO_OFF_ACC, 32'h1234);
    // byte and word input from the highest immediate port
    run(ctl(2'h0, 3'h0, 6'h0, 8'hFF));
    chk(periph_u.last_port, 16'h00FF);
    rdchk(`PIO_OFF_ACC, 32'h0000_1200);
    run(ctl(2'h0, 3'h1, 6'h0, 8'hFF));
    chk(periph_u.last_port, 16'h00FE);
    rdchk(`PIO_OFF_ACC, 32'h0000_FF01);
    // output through the index register at the top of its range
    xfer(1'b1, `PIO_OFF_PIDX, 32'hFFFF);
    run(ctl(2'h1, 3'h3, 6'h0, 8'h0));
    chk({periph_u.last_port, periph_u.last_wdata}, 32'hFFFE_FF01);
    run(ctl(2'h1, 3'h2, 6'h0, 8'h0));
    chk({periph_u.last_port, periph_u.last_wdata}, 32'hFFFF_0001);
    // privilege table, including real mode with the weakest level
    for (int k = 0; k < 5; k++) begin
      run(ctl(2'h1, 3'h0, pv[k], 8'h42));
      chk(rv[1:0], pf[k] ? 2'h2 : 2'h1);
      chk(periph_u.n_io - n0, pf[k] ? 0 : 1);
      chk(n_flt - f0, pf[k]);
      chk(irq, 1'b1);
    end
    xfer(1'b1, `PIO_OFF_STAT, 32'h3);
    @(posedge hclk);
    #1;
    chk(irq, 1'b0);
    xfer(1'b1, `PIO_OFF_MASK, 32'h1);
    run(ctl(2'h1, 3'h0, pv[0], 8'h42));
    chk({rv[1:0], irq}, 3'h4);
    // repeated byte block read counting up
    setup(16'h1234, 16'h1, 16'h5, 16'h10, 16'h0, 16'h3);
    run(ctl(2'h2, 3'h4, 6'h0, 8'h0));
    chk(periph_u.n_io - n0, 3);
    rdchk(`PIO_OFF_CNT, 32'h0);
    rdchk(`PIO_OFF_DIDX, 32'h13);
    chk({periph_u.m[8'h20][7:0], periph_u.m[8'h22][7:0], periph_u.m[8'h23]}, 32'hCBCB_A023);
    // repeated word block read counting down from an odd port number
    setup(16'h0101, 16'h0, 16'h5, 16'h40, 16'h0, 16'h2);
    run(ctl(2'h2, 3'h5, 6'h20, 8'h0));
    chk({periph_u.last_port, periph_u.m[8'h3E]}, 32'h0100_FEFF);
    chk({periph_u.m[8'h40], periph_u.m[8'h3C]}, 32'hFEFF_A03C);
    rdchk(`PIO_OFF_DIDX, 32'h3C);
    // repeated word block write counting down
    setup(16'h0077, 16'h0, 16'h2, 16'h0, 16'h8, 16'h2);
    run(ctl(2'h3, 3'h5, 6'h20, 8'h0));
    chk({periph_u.last_port, periph_u.last_wdata}, 32'h0076_A026);
    chk(periph_u.n_io - n0, 2);
    rdchk(`PIO_OFF_SIDX, 32'h4);
    // single byte block write without repeat keeps the count
    setup(16'h0077, 16'h0, 16'h2, 16'h0, 16'h10, 16'h5);
    run(ctl(2'h3, 3'h0, 6'h0, 8'h0));
    chk({periph_u.last_port, periph_u.last_wdata}, 32'h0077_0030);
    rdchk(`PIO_OFF_SIDX, 32'h11);
    rdchk(`PIO_OFF_CNT, 32'h5);
    // repeat with an empty count moves nothing
    setup(16'h0077, 16'h0, 16'h2, 16'h0, 16'h10, 16'h0);
    run(ctl(2'h3, 3'h4, 6'h0, 8'h0));
    chk({rv[1:0], 30'(periph_u.n_io - n0)}, 32'h4000_0000);
    rdchk(`PIO_OFF_SIDX, 32'h10);
    results();
  end
endmodule
